// >>> design/bfm_pkg.sv
// constants, register map and reset values of the buck2 fault monitor
// Summary of operation
// - Compare buck2 feedback samples against thresholds to derive overvoltage and undervoltage.
// - Overvoltage drives power-ok output A when its routing bit is one.
// - Overvoltage drives power-ok output B when its routing bit is one.
// - Undervoltage drives power-ok output A when its routing bit is one.
// - Undervoltage drives power-ok output B when its routing bit is one.
// - A detected fault sets its sticky flag to one and holds it.
// - Writing one clears a sticky flag unless its fault is still live; writing zero leaves it unchanged.
// - Read-only live bits follow present fault state; writes to them do nothing.
package bfm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int BFM_ADDR_W   = 8;
    localparam int BFM_DATA_W   = 32;
    localparam int BFM_SAMPLE_W = 10;
    localparam int BFM_FILT_W   = 4;
    localparam int BFM_CTRL_W   = 5;
    localparam int BFM_FLAG_N   = 2;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] BFM_OFF_CTRL   = 8'h00;
    localparam logic [7:0] BFM_OFF_OVTHR  = 8'h04;
    localparam logic [7:0] BFM_OFF_UVTHR  = 8'h08;
    localparam logic [7:0] BFM_OFF_FILT   = 8'h0c;
    localparam logic [7:0] BFM_OFF_STAT   = 8'h10;
    localparam logic [7:0] BFM_OFF_MASK   = 8'h14;
    localparam logic [7:0] BFM_OFF_LIVE   = 8'h18;
    localparam logic [7:0] BFM_OFF_SAMPLE = 8'h1c;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BFM_CTRL_OV_A  = 0;
    localparam int BFM_CTRL_OV_B  = 1;
    localparam int BFM_CTRL_UV_A  = 2;
    localparam int BFM_CTRL_UV_B  = 3;
    localparam int BFM_CTRL_MONEN = 4;
    localparam int BFM_FLAG_UV    = 0;
    localparam int BFM_FLAG_OV    = 1;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [4:0] BFM_CTRL_RST  = 5'h10;
    localparam logic [9:0] BFM_OVTHR_RST = 10'h3a0;
    localparam logic [9:0] BFM_UVTHR_RST = 10'h320;
    localparam logic [3:0] BFM_FILT_RST  = 4'h2;
    localparam logic [1:0] BFM_MASK_RST  = 2'h0;
    localparam logic [1:0] BFM_FLAG_RST  = 2'h0;

endpackage

// >>> design/bfm_fault_filter.sv
// consecutive-sample filter that turns a raw compare into a live fault level
module bfm_fault_filter
    import bfm_pkg::*;
(
    input  wire logic                  clk,         // system clock
    input  wire logic                  rst,         // async reset, high
    input  wire logic                  ce,          // clock enable
    input  wire logic                  enable,      // monitor enable
    input  wire logic                  sampleValid, // new compare result
    input  wire logic                  rawFault,    // unfiltered compare
    input  wire logic [BFM_FILT_W-1:0] filterLen,   // samples to agree
    output logic                       faultLive    // filtered fault level
);

    logic [BFM_FILT_W-1:0] cnt_q;
    logic [BFM_FILT_W:0]   cntNext;
    logic [BFM_FILT_W:0]   lenEff;

    // a length of zero behaves as one sample
    assign lenEff  = (filterLen == '0) ? (BFM_FILT_W+1)'(1) : {1'b0, filterLen};
    assign cntNext = {1'b0, cnt_q} + (BFM_FILT_W+1)'(1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            faultLive <= 1'b0;
            cnt_q     <= '0;
        end else if (ce) begin
            if (!enable) begin
                faultLive <= 1'b0;
                cnt_q     <= '0;
            end else if (sampleValid) begin
                if (rawFault == faultLive) begin
                    cnt_q <= '0;
                end else if (cntNext >= lenEff) begin
                    faultLive <= rawFault;
                    cnt_q     <= '0;
                end else begin
                    cnt_q <= cntNext[BFM_FILT_W-1:0];
                end
            end
        end
    end

endmodule

// >>> design/bfm_sticky_flags.sv
// write-one-to-clear sticky fault flags, set wins over clear
module bfm_sticky_flags
    import bfm_pkg::*;
(
    input  wire logic                  clk,       // system clock
    input  wire logic                  rst,       // async reset, high
    input  wire logic                  ce,        // clock enable
    input  wire logic [BFM_FLAG_N-1:0] setEvent,  // live fault levels
    input  wire logic [BFM_FLAG_N-1:0] clearReq,  // one-cycle clear bits
    output logic      [BFM_FLAG_N-1:0] flags      // sticky flag state
);

    for (genvar i = 0; i < BFM_FLAG_N; i++) begin : g_flag
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                flags[i] <= BFM_FLAG_RST[i];
            end else if (ce) begin
                if (setEvent[i]) begin
                    flags[i] <= 1'b1;
                end else if (clearReq[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    end

endmodule

// >>> design/bfm_fault_monitor.sv
// buck2 fault monitor top: compare, filter, routing, flags and registers
//
// The placing of the registers and strobed register access were left to the implementer.
module bfm_fault_monitor
    import bfm_pkg::*;
(
    input  wire logic                    clk,           // 50 MHz system clock
    input  wire logic                    rst,           // async reset, high
    input  wire logic                    ce,            // clock enable
    input  wire logic [BFM_ADDR_W-1:0]   regAddr,       // register byte address
    input  wire logic [BFM_DATA_W-1:0]   regWrData,     // write data
    input  wire logic                    regWrStrobe,   // write strobe
    input  wire logic                    regRdStrobe,   // read strobe
    output logic      [BFM_DATA_W-1:0]   regRdData,     // read data, next cycle
    input  wire logic [BFM_SAMPLE_W-1:0] fbSample,      // feedback node sample
    input  wire logic                    fbSampleValid, // sample strobe
    output logic                         powerOkOutA,   // fault on output A
    output logic                         powerOkOutB,   // fault on output B
    output logic                         irq            // interrupt level
);

    ////////////////////////////////////////////////////////////////////////
    // address decode helper

    function automatic logic regHit(
        input logic [BFM_ADDR_W-1:0] addr,
        input logic [BFM_ADDR_W-1:0] offset
    );
        regHit = (addr == offset);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [BFM_CTRL_W-1:0]   ctrl_q;
    logic [BFM_SAMPLE_W-1:0] ovThresh_q;
    logic [BFM_SAMPLE_W-1:0] uvThresh_q;
    logic [BFM_FILT_W-1:0]   filterLen_q;
    logic [BFM_FLAG_N-1:0]   mask_q;
    logic [BFM_SAMPLE_W-1:0] lastSample_q;
    logic [BFM_DATA_W-1:0]   rdData_d;

    logic [BFM_FLAG_N-1:0]   rawFault;
    logic [BFM_FLAG_N-1:0]   faultLive;
    logic [BFM_FLAG_N-1:0]   stickyFlags;
    logic [BFM_FLAG_N-1:0]   flagClear;

    logic                    buck2OvervoltLive;
    logic                    buck2UndervoltLive;
    logic                    buck2OvervoltSticky;
    logic                    buck2UndervoltSticky;

    logic                    cfgOvToPowerOkA;
    logic                    cfgOvToPowerOkB;
    logic                    cfgUvToPowerOkA;
    logic                    cfgUvToPowerOkB;
    logic                    monitorEnable;

    logic                    powerOkA_d;
    logic                    powerOkB_d;

    logic                    wrCtrl;
    logic                    wrOvThr;
    logic                    wrUvThr;
    logic                    wrFilt;
    logic                    wrStat;
    logic                    wrMask;

    ////////////////////////////////////////////////////////////////////////
    // write decode

    assign wrCtrl  = regWrStrobe && regHit(regAddr, BFM_OFF_CTRL);
    assign wrOvThr = regWrStrobe && regHit(regAddr, BFM_OFF_OVTHR);
    assign wrUvThr = regWrStrobe && regHit(regAddr, BFM_OFF_UVTHR);
    assign wrFilt  = regWrStrobe && regHit(regAddr, BFM_OFF_FILT);
    assign wrStat  = regWrStrobe && regHit(regAddr, BFM_OFF_STAT);
    assign wrMask  = regWrStrobe && regHit(regAddr, BFM_OFF_MASK);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= BFM_CTRL_RST;
        end else if (ce && wrCtrl) begin
            ctrl_q <= regWrData[BFM_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovThresh_q <= BFM_OVTHR_RST;
        end else if (ce && wrOvThr) begin
            ovThresh_q <= regWrData[BFM_SAMPLE_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uvThresh_q <= BFM_UVTHR_RST;
        end else if (ce && wrUvThr) begin
            uvThresh_q <= regWrData[BFM_SAMPLE_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filterLen_q <= BFM_FILT_RST;
        end else if (ce && wrFilt) begin
            filterLen_q <= regWrData[BFM_FILT_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= BFM_MASK_RST;
        end else if (ce && wrMask) begin
            mask_q <= regWrData[BFM_FLAG_N-1:0];
        end
    end

    assign cfgOvToPowerOkA = ctrl_q[BFM_CTRL_OV_A];
    assign cfgOvToPowerOkB = ctrl_q[BFM_CTRL_OV_B];
    assign cfgUvToPowerOkA = ctrl_q[BFM_CTRL_UV_A];
    assign cfgUvToPowerOkB = ctrl_q[BFM_CTRL_UV_B];
    assign monitorEnable   = ctrl_q[BFM_CTRL_MONEN];

    ////////////////////////////////////////////////////////////////////////
    // threshold compare of the feedback node

    // window compare, above the upper bound or below the lower bound
    assign rawFault[BFM_FLAG_OV] = (fbSample > ovThresh_q);
    assign rawFault[BFM_FLAG_UV] = (fbSample < uvThresh_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lastSample_q <= '0;
        end else if (ce && fbSampleValid) begin
            lastSample_q <= fbSample;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // filtering into live fault levels

    for (genvar i = 0; i < BFM_FLAG_N; i++) begin : g_filt
        bfm_fault_filter u_filter (
            .clk         (clk),
            .rst         (rst),
            .ce          (ce),
            .enable      (monitorEnable),
            .sampleValid (fbSampleValid),
            .rawFault    (rawFault[i]),
            .filterLen   (filterLen_q),
            .faultLive   (faultLive[i])
        );
    end

    // live bits are never latched
    assign buck2OvervoltLive  = faultLive[BFM_FLAG_OV];
    assign buck2UndervoltLive = faultLive[BFM_FLAG_UV];

    ////////////////////////////////////////////////////////////////////////
    // sticky flags, write one to clear

    assign flagClear = wrStat ? regWrData[BFM_FLAG_N-1:0] : '0;

    bfm_sticky_flags u_sticky (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .setEvent (faultLive),
        .clearReq (flagClear),
        .flags    (stickyFlags)
    );

    assign buck2OvervoltSticky  = stickyFlags[BFM_FLAG_OV];
    assign buck2UndervoltSticky = stickyFlags[BFM_FLAG_UV];

    ////////////////////////////////////////////////////////////////////////
    // power-ok routing

    always_comb begin
        powerOkA_d = 1'b0;
        powerOkB_d = 1'b0;
        if (cfgOvToPowerOkA && buck2OvervoltLive) begin
            powerOkA_d = 1'b1;
        end
        if (cfgOvToPowerOkB && buck2OvervoltLive) begin
            powerOkB_d = 1'b1;
        end
        if (cfgUvToPowerOkA && buck2UndervoltLive) begin
            powerOkA_d = 1'b1;
        end
        if (cfgUvToPowerOkB && buck2UndervoltLive) begin
            powerOkB_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powerOkOutA <= 1'b0;
            powerOkOutB <= 1'b0;
        end else if (ce) begin
            powerOkOutA <= powerOkA_d;
            powerOkOutB <= powerOkB_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt

    assign irq = |(stickyFlags & mask_q);

    ////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        rdData_d = '0;
        if (regHit(regAddr, BFM_OFF_CTRL)) begin
            rdData_d[BFM_CTRL_W-1:0] = ctrl_q;
        end else if (regHit(regAddr, BFM_OFF_OVTHR)) begin
            rdData_d[BFM_SAMPLE_W-1:0] = ovThresh_q;
        end else if (regHit(regAddr, BFM_OFF_UVTHR)) begin
            rdData_d[BFM_SAMPLE_W-1:0] = uvThresh_q;
        end else if (regHit(regAddr, BFM_OFF_FILT)) begin
            rdData_d[BFM_FILT_W-1:0] = filterLen_q;
        end else if (regHit(regAddr, BFM_OFF_STAT)) begin
            rdData_d[BFM_FLAG_UV] = buck2UndervoltSticky;
            rdData_d[BFM_FLAG_OV] = buck2OvervoltSticky;
        end else if (regHit(regAddr, BFM_OFF_MASK)) begin
            rdData_d[BFM_FLAG_N-1:0] = mask_q;
        end else if (regHit(regAddr, BFM_OFF_LIVE)) begin
            rdData_d[BFM_FLAG_UV] = buck2UndervoltLive;
            rdData_d[BFM_FLAG_OV] = buck2OvervoltLive;
        end else if (regHit(regAddr, BFM_OFF_SAMPLE)) begin
            rdData_d[BFM_SAMPLE_W-1:0] = lastSample_q;
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= '0;
        end else if (ce) begin
            if (regRdStrobe) begin
                regRdData <= rdData_d;
            end else begin
                regRdData <= '0;
            end
        end
    end

endmodule

// >>> tb/bfm_fault_monitor_asserts.sv
// port checker of the buck2 fault monitor, bound to the top
module bfm_asserts
    import bfm_pkg::*;
(
    input wire logic                    clk,           // clock
    input wire logic                    rst,           // async reset, high
    input wire logic                    ce,            // clock enable
    input wire logic [BFM_ADDR_W-1:0]   regAddr,       // register address
    input wire logic [BFM_DATA_W-1:0]   regWrData,     // write data
    input wire logic                    regWrStrobe,   // write strobe
    input wire logic                    regRdStrobe,   // read strobe
    input wire logic [BFM_DATA_W-1:0]   regRdData,     // read data
    input wire logic [BFM_SAMPLE_W-1:0] fbSample,      // feedback sample
    input wire logic                    fbSampleValid, // sample strobe
    input wire logic                    powerOkOutA,   // output A
    input wire logic                    powerOkOutB,   // output B
    input wire logic                    irq            // interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // shadow of routing and mask registers
    logic [4:0] ctrlQ;
    logic [1:0] maskQ;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlQ <= BFM_CTRL_RST;
            maskQ <= BFM_MASK_RST;
        end else if (ce && regWrStrobe && regAddr == BFM_OFF_CTRL) begin
            ctrlQ <= regWrData[4:0];
        end else if (ce && regWrStrobe && regAddr == BFM_OFF_MASK) begin
            maskQ <= regWrData[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property ($past(rst) |-> !irq && !powerOkOutA && !powerOkOutB)
        else $error("outputs not quiet after reset");
    a_rd_idle_zero: assert property ($past(ce) && !$past(regRdStrobe) |-> regRdData == '0)
        else $error("read data not zero outside read slot");
    a_unmapped_rd: assert property (ce && regRdStrobe && regAddr > BFM_OFF_SAMPLE
        |=> regRdData == '0)
        else $error("unmapped read not zero");
    a_pok_a_route: assert property (powerOkOutA
        |-> ctrlQ[0] || ctrlQ[2] || $past(ctrlQ[0]) || $past(ctrlQ[2]))
        else $error("output A high without routing");
    a_pok_b_route: assert property (powerOkOutB
        |-> ctrlQ[1] || ctrlQ[3] || $past(ctrlQ[1]) || $past(ctrlQ[3]))
        else $error("output B high without routing");
    a_irq_masked: assert property (irq |-> |maskQ)
        else $error("interrupt with all sources masked");
    a_irq_stat: assert property (ce && regRdStrobe && regAddr == BFM_OFF_STAT && irq
        |=> |regRdData[1:0] && regRdData[31:2] == '0)
        else $error("status read disagrees with interrupt");
    a_live_width: assert property (ce && regRdStrobe && regAddr == BFM_OFF_LIVE
        |=> regRdData[31:2] == '0)
        else $error("live read has upper bits set");
    c_pok_a: cover property (powerOkOutA);
    c_pok_b: cover property (powerOkOutB);
    c_irq: cover property (irq);
endmodule
bind bfm_fault_monitor bfm_asserts u_chk (.clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(regRdData), .fbSample(fbSample), .fbSampleValid(fbSampleValid),
    .powerOkOutA(powerOkOutA), .powerOkOutB(powerOkOutB), .irq(irq));

// >>> tb/tb_top.sv
// self-checking testbench of the buck2 fault monitor
module tb_top
    import bfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        ce       = 1'b1;
    logic        wrS      = 1'b0;
    logic        rdS      = 1'b0;
    logic        sVal     = 1'b0;
    logic        rdPend   = 1'b0;
    logic [7:0]  addr     = '0;
    logic [31:0] wData    = '0;
    logic [9:0]  sample   = '0;
    logic [31:0] rData;
    logic        pokA;
    logic        pokB;
    logic        irq;
    logic [31:0] expQ[$];
    logic [2:0]  pinQ[$];
    int          errorCnt = 0;
    int          testsRun = 0;
    bfm_fault_monitor u_dut (.clk(clk), .rst(rst), .ce(ce), .regAddr(addr), .regWrData(wData),
        .regWrStrobe(wrS), .regRdStrobe(rdS), .regRdData(rData), .fbSample(sample),
        .fbSampleValid(sVal), .powerOkOutA(pokA), .powerOkOutB(pokB), .irq(irq));
    initial begin
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic cmpRd(logic [31:0] e, logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            errorCnt++;
            $display("[ERR] regRdData expected %h seen %h", e, g);
        end
    endtask
    task automatic cmpPin(logic [2:0] e, logic [2:0] g);
        testsRun++;
        if (g !== e) begin
            errorCnt++;
            $display("[ERR] powerOkOutA,powerOkOutB,irq expected %b seen %b", e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wData <= d;
        wrS   <= 1'b1;
        @(posedge clk);
        wrS <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        expQ.push_back(e);
        addr <= a;
        rdS  <= 1'b1;
        @(posedge clk);
        rdS <= 1'b0;
    endtask
    // note of {powerOkOutA, powerOkOutB, irq}, checked at the next falling edge
    task automatic expPins(logic [2:0] e);
        pinQ.push_back(e);
        @(posedge clk);
    endtask
    task automatic feed(logic [9:0] v, int n);
        repeat (n) begin
            @(posedge clk);
            sample <= v;
            sVal   <= 1'b1;
        end
        @(posedge clk);
        sVal   <= 1'b0;
        sample <= ~v;
        repeat (3) @(posedge clk);
    endtask
    task automatic conclude();
        if (expQ.size() != 0 || pinQ.size() != 0) begin
            errorCnt++;
        end
        if (errorCnt == 0 && testsRun > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        rdPend <= rdS && ce;
        if (rdPend) begin
            cmpRd(expQ.pop_front(), rData);
        end
    end
    always @(negedge clk) begin
        if (pinQ.size() != 0) begin
            cmpPin(pinQ.pop_front(), {pokA, pokB, irq});
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [9:0] flt;
        logic [9:0] mid;
        logic [1:0] bit1;
        void'($urandom(9));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(BFM_OFF_CTRL, 32'(BFM_CTRL_RST));
        rd(BFM_OFF_OVTHR, 32'(BFM_OVTHR_RST));
        rd(BFM_OFF_UVTHR, 32'(BFM_UVTHR_RST));
        rd(BFM_OFF_FILT, 32'(BFM_FILT_RST));
        rd(BFM_OFF_STAT, 32'h0);
        rd(8'h20, 32'h0);
        mid = 10'($urandom);
        wr(BFM_OFF_OVTHR, 32'hffff_fc00 | 32'(mid));
        rd(BFM_OFF_OVTHR, 32'(mid));
        wr(BFM_OFF_OVTHR, 32'(BFM_OVTHR_RST));
        wr(BFM_OFF_MASK, 32'h3);
        for (int k = 0; k < 4; k++) begin
            flt  = (k < 2) ? 10'h3ff : 10'h000;
            bit1 = (k < 2) ? 2'h2 : 2'h1;
            wr(BFM_OFF_CTRL, 32'h10 | (32'h1 << k));
            feed(flt, 2);
            expPins({1'(k == 0 || k == 2), 1'(k == 1 || k == 3), 1'h1});
            rd(BFM_OFF_LIVE, 32'(bit1));
            wr(BFM_OFF_STAT, 32'h3);
            rd(BFM_OFF_STAT, 32'(bit1));
            mid = BFM_UVTHR_RST + 10'($urandom_range(0, 128));
            feed(mid, 2);
            expPins(3'h1);
            rd(BFM_OFF_LIVE, 32'h0);
            rd(BFM_OFF_SAMPLE, 32'(mid));
            wr(BFM_OFF_STAT, 32'h0);
            rd(BFM_OFF_STAT, 32'(bit1));
            wr(BFM_OFF_STAT, 32'(bit1));
            rd(BFM_OFF_STAT, 32'h0);
            expPins(3'h0);
        end
        // three agreeing samples needed, split over two bursts
        wr(BFM_OFF_FILT, 32'h3);
        feed(10'h000, 2);
        rd(BFM_OFF_LIVE, 32'h0);
        feed(10'h000, 1);
        rd(BFM_OFF_LIVE, 32'h1);
        expPins(3'h3);
        // a length of zero acts as one sample
        wr(BFM_OFF_FILT, 32'h0);
        feed(BFM_OVTHR_RST, 1);
        rd(BFM_OFF_LIVE, 32'h0);
        wr(BFM_OFF_STAT, 32'h3);
        rd(BFM_OFF_STAT, 32'h0);
        wr(BFM_OFF_FILT, 32'(BFM_FILT_RST));
        // monitor disabled: no live fault, no sticky set
        wr(BFM_OFF_CTRL, 32'h0f);
        feed(10'h3ff, 2);
        rd(BFM_OFF_LIVE, 32'h0);
        rd(BFM_OFF_STAT, 32'h0);
        expPins(3'h0);
        // clock enable low freezes registers and the fault path
        wr(BFM_OFF_CTRL, 32'h1f);
        @(posedge clk);
        ce <= 1'b0;
        wr(BFM_OFF_CTRL, 32'h10);
        feed(10'h3ff, 2);
        expPins(3'h0);
        @(posedge clk);
        ce <= 1'b1;
        rd(BFM_OFF_CTRL, 32'h1f);
        rd(BFM_OFF_LIVE, 32'h0);
        wr(BFM_OFF_MASK, 32'h0);
        feed(10'h3ff, 2);
        expPins(3'h6);
        wr(BFM_OFF_LIVE, 32'h0);
        rd(BFM_OFF_LIVE, 32'h2);
        wr(BFM_OFF_MASK, 32'h2);
        expPins(3'h7);
        rd(BFM_OFF_STAT, 32'h2);
        // reset in mid-run returns status, mask and control registers to their reset values
        repeat (2) @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        expPins(3'h0);
        rd(BFM_OFF_STAT, 32'h0);
        rd(BFM_OFF_MASK, 32'(BFM_MASK_RST));
        rd(BFM_OFF_CTRL, 32'(BFM_CTRL_RST));
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule
